// ---- design/rxd_pkg.sv ----
/*
  rxd_pkg: constants, field layouts and carriers for the receive
  descriptor list engine.
  Assumes a 32-bit system memory reached by single-word accesses.
*/
package rxd_pkg;
  // ----------------------------------------------------------------
  // register port offsets and command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD  = 4'h0;
  localparam logic [3:0] ADDR_FRDA = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [1:0] CMD_START   = 2'h1;
  localparam logic [1:0] CMD_HOLDRST = 2'h2;
  localparam logic [1:0] CMD_ABORT   = 2'h3;
  localparam int         CMD_CODE_LSB = 8;

  // ----------------------------------------------------------------
  // descriptor word offsets and vector types
  // ----------------------------------------------------------------
  localparam logic [31:0] DW_CTRL = 32'h0000_0000;
  localparam logic [31:0] DW_LINK = 32'h0000_0004;
  localparam logic [31:0] DW_DPTR = 32'h0000_0008;
  localparam logic [31:0] DW_STAT = 32'h0000_000C;
  localparam logic [15:0] WORD_BYTES = 16'h0004;
  localparam logic [1:0]  VEC_PKT_END = 2'h1;
  localparam logic [1:0]  VEC_HOST    = 2'h2;

  // descriptor word 0
  typedef struct packed {
    logic        zero;
    logic        hold;
    logic        host_irq_request;
    logic [2:0]  hdr_offset;
    logic [3:0]  rsv;
    logic [5:0]  descriptor_tag;
    logic [15:0] size;
  } rxd_ctrl_s;

  // receive error flags as they sit in the status word
  typedef struct packed {
    logic over_length_error;
    logic rx_overflow_error;
    logic crc_error;
    logic bit_length_error;
    logic rx_abort_flag;
  } rxd_err_s;

  // descriptor word 3
  typedef struct packed {
    logic        packet_end_flag;
    logic        complete;
    logic [8:0]  zero;
    rxd_err_s    err;
    logic [15:0] stored_byte_count;
  } rxd_stat_s;

  // per-channel database entry
  typedef struct packed {
    logic        active;
    logic        valid;
    logic        pkt_start;
    rxd_ctrl_s   ctrl;
    logic [29:0] next_rx_link;
    logic [29:0] rx_buffer_pointer;
    logic [29:0] cur;
    logic [15:0] used;
  } rxd_db_s;

  // channel interrupt vector
  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] descriptor_tag;
    logic [7:0] ch;
  } rxd_vec_s;
endpackage

// ---- design/rxd_dma.sv ----
/*
  rxd_dma: receive descriptor list engine for 256 channels.
  Assumes memory answers each request with one MEM_ACK_I pulse and that
  the receive buffer holds a request steady until RXB_ACK_O.
*/
// The plain strobed port and the placing of the registers were decided locally.
//
// What this block does
// - descriptor is four words, device writes fourth
// - section size from word 0, max 65535
// - packet end flagged, next descriptor starts packet
// - transmit pointers may start unaligned
// - fetch on receive command or on branch
// - branch reads three words into channel database
// - word 0 holds hold, irq, offset, tag, size
// - status word layout written back exactly
// - hold clear: branch to next link
// - hold set: repoll same descriptor once
// - still held: channel off until command
// - repoll updates only hold and link
// - independent list for each of 256 channels
// - same layout for receive and transmit
// - host vector after data and status
// - first descriptor writes at pointer plus offset
// - complete bit hands descriptor back
// - vector carries descriptor tag
`timescale 1ns/1ps
module rxd_dma
  import rxd_pkg::*;
#(
  parameter int CHANNELS = 256
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic [3:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic [31:0]      MEM_ADDR_O,
  output logic [31:0]      MEM_WDATA_O,
  input  wire logic        MEM_ACK_I,
  input  wire logic [31:0] MEM_RDATA_I,
  input  wire logic        RXB_REQ_I,
  input  wire logic [7:0]  RXB_CH_I,
  input  wire logic [15:0] RXB_LEN_I,
  input  wire logic        RXB_EOP_I,
  input  wire rxd_err_s    RXB_ERR_I,
  input  wire logic [31:0] RXB_DATA_I,
  output logic             RXB_POP_O,
  output logic             RXB_ACK_O,
  output logic             VEC_VALID_O,
  output rxd_vec_s         VEC_O
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_NEXT, S_XFER, S_STAT, S_VEC, S_POLL
  } rxd_st_e;

  typedef struct packed {
    rxd_st_e     st;
    logic [7:0]  ch;
    logic [1:0]  wcnt;
    logic        has_req;
    logic [15:0] rem;
    logic [15:0] nb;
    logic        eop;
    rxd_err_s    err;
    logic        fe;
    logic        abort;
    logic        vec_fe;
    logic        vec_host;
    logic        cmd_pend;
    logic [1:0]  cmd_code;
    logic [7:0]  cmd_ch;
    logic [29:0] frda;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] rdata;
    logic        pop;
    logic        ack;
    logic        vec_valid;
    rxd_vec_s    vec;
  } rxd_state_s;

  rxd_state_s s_r;
  rxd_state_s s_nxt;
  rxd_db_s    db [CHANNELS];     // one list per channel
  rxd_db_s    d;
  rxd_db_s    dn;
  logic       db_we;
  logic [7:0]  db_wi;
  logic [15:0] offb;
  logic [15:0] room;
  logic [15:0] step;
  logic [31:0] desc_base;
  rxd_stat_s   stw;

  // ----------------------------------------------------------------
  // derived values for the selected channel
  // ----------------------------------------------------------------
  assign d         = db[s_r.ch];
  assign desc_base = {d.cur, 2'b00};
  // header space only in a packet's first descriptor
  assign offb = d.pkt_start ? {11'h000, d.ctrl.hdr_offset, 2'b00} : 16'h0000;
  assign room = d.ctrl.size - offb - d.used;
  assign step = (s_r.nb > WORD_BYTES) ? WORD_BYTES : s_r.nb;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    dn              = d;
    db_we           = 1'b0;
    db_wi           = s_r.ch;
    stw             = '0;
    s_nxt.pop       = 1'b0;
    s_nxt.ack       = 1'b0;
    s_nxt.vec_valid = 1'b0;
    unique case (s_r.st)
      S_IDLE: begin
        s_nxt.abort = 1'b0;
        if (s_r.cmd_pend) begin
          s_nxt.cmd_pend = 1'b0;
          s_nxt.ch       = s_r.cmd_ch;
          s_nxt.has_req  = 1'b0;
          s_nxt.wcnt     = 2'h0;
          unique case (s_r.cmd_code)
            CMD_START: begin
              // receive command fetches the first descriptor
              dn           = db[s_r.cmd_ch];
              db_wi        = s_r.cmd_ch;     // entry of the commanded channel
              dn.cur       = s_r.frda;
              dn.active    = 1'b1;
              dn.valid     = 1'b0;
              dn.pkt_start = 1'b1;
              db_we        = 1'b1;
              s_nxt.st     = S_FETCH;
            end
            CMD_HOLDRST: begin
              // held channel resumes through a fresh poll
              if (db[s_r.cmd_ch].valid && !db[s_r.cmd_ch].active) begin
                s_nxt.st = S_POLL;
              end
            end
            CMD_ABORT: begin
              s_nxt.abort = 1'b1;
              s_nxt.fe    = 1'b0;
              s_nxt.err   = '0;
              s_nxt.st    = db[s_r.cmd_ch].valid ? S_STAT : S_VEC;
            end
            default: ;
          endcase
        end else if (RXB_REQ_I && !s_r.ack) begin   // request still up in ack cycle
          s_nxt.ch      = RXB_CH_I;
          s_nxt.has_req = 1'b1;
          s_nxt.rem     = RXB_LEN_I;
          s_nxt.eop     = RXB_EOP_I;
          s_nxt.err     = RXB_ERR_I;
          s_nxt.wcnt    = 2'h0;
          if (!db[RXB_CH_I].active) begin
            s_nxt.ack = 1'b1;                       // inactive: data dropped
          end else begin
            s_nxt.st = db[RXB_CH_I].valid ? S_NEXT : S_FETCH;
          end
        end
      end
      S_FETCH: begin
        // three link and packet words into the database
        if (!s_r.mem_req) begin
          s_nxt.mem_req  = 1'b1;
          s_nxt.mem_we   = 1'b0;
          s_nxt.mem_addr = desc_base + {28'h0, s_r.wcnt, 2'b00};
        end else if (MEM_ACK_I) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.wcnt    = s_r.wcnt + 2'h1;
          db_we         = 1'b1;
          unique case (s_r.wcnt)
            2'h0:    dn.ctrl = rxd_ctrl_s'(MEM_RDATA_I);
            2'h1:    dn.next_rx_link = MEM_RDATA_I[31:2];
            default: begin
              dn.rx_buffer_pointer = MEM_RDATA_I[31:2]; // byte lanes unused here
              dn.valid             = 1'b1;
              dn.used              = 16'h0000;
              s_nxt.st             = S_NEXT;
            end
          endcase
        end
      end
      S_NEXT: begin
        if (!s_r.has_req) begin
          s_nxt.st = S_IDLE;
        end else if (room == 16'h0000) begin
          s_nxt.fe = 1'b0;
          s_nxt.st = S_STAT;                        // section already full
        end else if (s_r.rem == 16'h0000) begin
          s_nxt.ack = 1'b1;
          s_nxt.st  = S_IDLE;
        end else begin
          s_nxt.nb = (s_r.rem < room) ? s_r.rem : room;
          s_nxt.st = S_XFER;
        end
      end
      S_XFER: begin
        if (!s_r.mem_req) begin
          s_nxt.mem_req   = 1'b1;
          s_nxt.mem_we    = 1'b1;
          s_nxt.mem_addr  = {d.rx_buffer_pointer, 2'b00} + {16'h0000, offb + d.used};
          s_nxt.mem_wdata = RXB_DATA_I;
          s_nxt.pop       = 1'b1;
        end else if (MEM_ACK_I) begin
          s_nxt.mem_req = 1'b0;
          dn.used       = d.used + step;
          db_we         = 1'b1;
          s_nxt.nb      = s_r.nb - step;
          s_nxt.rem     = s_r.rem - step;
          if (s_r.nb == step) begin
            // status only after the last data write
            if (s_r.eop && s_r.rem == step) begin
              s_nxt.fe = 1'b1;
              s_nxt.st = S_STAT;
            end else if (room == step) begin
              s_nxt.fe = 1'b0;
              s_nxt.st = S_STAT;
            end else begin
              s_nxt.ack = 1'b1;
              s_nxt.st  = S_IDLE;
            end
          end
        end
      end
      S_STAT: begin
        // status word hands the descriptor back
        stw.packet_end_flag   = s_r.fe;
        stw.complete          = 1'b1;
        stw.stored_byte_count = d.used;
        if (s_r.fe) begin
          stw.err = s_r.err;
        end
        if (s_r.abort) begin
          stw.err.rx_abort_flag = 1'b1;
        end
        if (!s_r.mem_req) begin
          s_nxt.mem_req   = 1'b1;
          s_nxt.mem_we    = 1'b1;
          s_nxt.mem_addr  = desc_base + DW_STAT;
          s_nxt.mem_wdata = stw;
        end else if (MEM_ACK_I) begin
          s_nxt.mem_req  = 1'b0;
          s_nxt.vec_fe   = s_r.fe;
          s_nxt.vec_host = d.ctrl.host_irq_request;
          s_nxt.st       = S_VEC;
        end
      end
      S_VEC: begin
        // vectors follow the status write
        s_nxt.vec.ch             = s_r.ch;
        s_nxt.vec.descriptor_tag = d.ctrl.descriptor_tag;
        s_nxt.wcnt               = 2'h0;
        if (s_r.vec_fe) begin
          s_nxt.vec_fe    = 1'b0;
          s_nxt.vec.kind  = VEC_PKT_END;
          s_nxt.vec_valid = 1'b1;
        end else if (s_r.vec_host) begin
          s_nxt.vec_host  = 1'b0;
          s_nxt.vec.kind  = VEC_HOST;
          s_nxt.vec_valid = 1'b1;
        end else begin
          db_we        = 1'b1;
          dn.pkt_start = s_r.fe || s_r.abort;
          dn.valid     = 1'b0;
          if (s_r.abort) begin
            dn.cur    = s_r.frda;                   // relink to new list
            dn.active = 1'b1;
            s_nxt.st  = S_FETCH;
          end else if (!d.ctrl.hold) begin
            dn.cur   = d.next_rx_link;
            s_nxt.st = S_FETCH;
          end else begin
            dn.valid = 1'b1;
            s_nxt.st = S_POLL;
          end
        end
      end
      S_POLL: begin
        // repoll reads words 0 and 1, keeps only hold and link
        if (!s_r.mem_req) begin
          s_nxt.mem_req  = 1'b1;
          s_nxt.mem_we   = 1'b0;
          s_nxt.mem_addr = desc_base + {28'h0, s_r.wcnt, 2'b00};
        end else if (MEM_ACK_I) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.wcnt    = s_r.wcnt + 2'h1;
          db_we         = 1'b1;
          if (s_r.wcnt == 2'h0) begin
            dn.ctrl.hold = MEM_RDATA_I[30];
          end else if (d.ctrl.hold) begin
            dn.next_rx_link = MEM_RDATA_I[31:2];
            dn.active       = 1'b0;
            s_nxt.ack       = s_r.has_req;
            s_nxt.has_req   = 1'b0;
            s_nxt.st        = S_IDLE;
          end else begin
            dn.next_rx_link = MEM_RDATA_I[31:2];
            dn.cur          = MEM_RDATA_I[31:2];
            dn.active       = 1'b1;
            dn.valid        = 1'b0;
            s_nxt.wcnt      = 2'h0;
            s_nxt.st        = S_FETCH;
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
    // register port: a command write wins over its consumption
    if (REG_WR_I && REG_ADDR_I == ADDR_CMD) begin
      s_nxt.cmd_pend = 1'b1;
      s_nxt.cmd_code = REG_WDATA_I[CMD_CODE_LSB+1:CMD_CODE_LSB];
      s_nxt.cmd_ch   = REG_WDATA_I[7:0];
    end
    if (REG_WR_I && REG_ADDR_I == ADDR_FRDA) begin
      s_nxt.frda = REG_WDATA_I[31:2];
    end
    s_nxt.rdata = 32'h0000_0000;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        ADDR_CMD:  s_nxt.rdata = {21'h0, s_r.cmd_pend, s_r.cmd_code, s_r.cmd_ch};
        ADDR_FRDA: s_nxt.rdata = {s_r.frda, 2'b00};
        ADDR_STAT: s_nxt.rdata = {27'h0, db[s_r.cmd_ch].pkt_start,
                                  db[s_r.cmd_ch].valid, db[s_r.cmd_ch].active,
                                  s_r.cmd_pend, (s_r.st != S_IDLE)};
        default:   s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and channel database
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        db[i] <= '0;
      end
    end else begin
      s_r <= s_nxt;
      if (db_we) begin
        db[db_wi] <= dn;
      end
    end
  end

  // outputs straight from the state register
  assign REG_RDATA_O = s_r.rdata;
  assign MEM_REQ_O   = s_r.mem_req;
  assign MEM_WE_O    = s_r.mem_we;
  assign MEM_ADDR_O  = s_r.mem_addr;
  assign MEM_WDATA_O = s_r.mem_wdata;
  assign RXB_POP_O   = s_r.pop;
  assign RXB_ACK_O   = s_r.ack;
  assign VEC_VALID_O = s_r.vec_valid;
  assign VEC_O       = s_r.vec;
endmodule

// ---- test/rxd_dma_properties.sv ----
/*
  rxd_dma_properties: port checks for the receive descriptor engine.
  Assumes one clock domain and RST_I active high.
*/
`timescale 1ns/1ps
module rxd_dma_chk
  import rxd_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic        MEM_REQ_O,
  input wire logic        MEM_WE_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic [31:0] MEM_WDATA_O,
  input wire logic        MEM_ACK_I,
  input wire logic [31:0] RXB_DATA_I,
  input wire logic        RXB_POP_O,
  input wire logic        RXB_ACK_O,
  input wire logic        VEC_VALID_O,
  input wire rxd_vec_s    VEC_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  mem_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
    && $stable(MEM_WE_O) && $stable(MEM_WDATA_O)) else $error("memory request moved early");
  mem_release_a: assert property (MEM_ACK_I |=> !MEM_REQ_O)
    else $error("memory request kept after ack");
  addr_align_a: assert property (MEM_REQ_O |-> MEM_ADDR_O[1:0] == 2'h0)
    else $error("memory address not word aligned");
  // ----------------------------------------------------------------
  // receive buffer, vectors and register reads
  // ----------------------------------------------------------------
  pop_data_a: assert property (RXB_POP_O |-> MEM_REQ_O && !$past(MEM_REQ_O)
    && MEM_WE_O && MEM_WDATA_O == $past(RXB_DATA_I)) else $error("pop without write");
  ack_pulse_a: assert property (RXB_ACK_O |=> !RXB_ACK_O)
    else $error("buffer ack longer than one cycle");
  ack_idle_a: assert property (RXB_ACK_O |-> !MEM_REQ_O)
    else $error("buffer ack while memory busy");
  vec_idle_a: assert property (VEC_VALID_O |-> !MEM_REQ_O)
    else $error("vector while memory busy");
  vec_order_a: assert property (VEC_VALID_O ##1 VEC_VALID_O |-> VEC_O.kind == VEC_HOST
    && $past(VEC_O.kind) == VEC_PKT_END) else $error("vector pair out of order");
  rd_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind rxd_dma rxd_dma_chk chk_u (.REF_CLK_I, .RST_I, .REG_RD_I, .REG_RDATA_O, .MEM_REQ_O,
  .MEM_WE_O, .MEM_ADDR_O, .MEM_WDATA_O, .MEM_ACK_I, .RXB_DATA_I, .RXB_POP_O, .RXB_ACK_O,
  .VEC_VALID_O, .VEC_O);

// ---- test/rxd_mem_model.sv ----
/*
  rxd_mem_model: host CPU and shared memory behind the memory port.
  Assumes one request at a time, held until its ack.
*/
`timescale 1ns/1ps
module rxd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [0:1023]; // four-word descriptors, hold-marked tails, aligned sections
  logic [3:0]  cnt_r;
  logic        done_r;
  // answer each request once, lat_i+1 cycles after it rises, data only with ack
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      if (ack_o) begin
        done_r <= 1'b1;
        rdata_o <= ~rdata_o; // released bus shows no stale word
      end
      if (!req_i) begin
        done_r <= 1'b0;
      end else if (!done_r && !ack_o) begin
        if (cnt_r == lat_i) begin
          ack_o <= 1'b1;
          cnt_r <= 4'h0;
          if (we_i) mem[addr_i[11:2]] <= wdata_i;
          else rdata_o <= mem[addr_i[11:2]];
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule

// ---- test/tb_rxd_dma.sv ----
/*
  tb_rxd_dma: scenario bench for the receive descriptor engine.
  Assumes the memory model answers every request.
*/
`timescale 1ns/1ps
module tb_rxd_dma
  import rxd_pkg::*;
;
  logic        clk, rst, wr, rd, mem_req, mem_we, mem_ack, rxb_req, rxb_eop, rxb_pop, rxb_ack;
  logic        vec_valid;
  logic [3:0]  addr, lat;
  logic [31:0] wdata, rdata, mem_addr, mem_wdata, mem_rdata, rd_val, widx, w0;
  logic [7:0]  rxb_ch;
  logic [15:0] rxb_len;
  rxd_err_s    rxb_err;
  rxd_vec_s    vec;
  rxd_vec_s    vq [$];
  int          n_fail, total_checks, rd_cnt [0:1023];
  wire  [31:0] rxb_data = 32'hD000_0000 + widx;

  rxd_dma #(.CHANNELS(256)) dut_u (.REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
    .MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata), .RXB_REQ_I(rxb_req), .RXB_CH_I(rxb_ch),
    .RXB_LEN_I(rxb_len), .RXB_EOP_I(rxb_eop), .RXB_ERR_I(rxb_err), .RXB_DATA_I(rxb_data),
    .RXB_POP_O(rxb_pop), .RXB_ACK_O(rxb_ack), .VEC_VALID_O(vec_valid), .VEC_O(vec));
  rxd_mem_model mem_u (.clk_i(clk), .rst_i(rst), .lat_i(lat), .req_i(mem_req), .we_i(mem_we),
    .addr_i(mem_addr), .wdata_i(mem_wdata), .ack_o(mem_ack), .rdata_o(mem_rdata));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // data word counter, read tally, vector log
  always @(posedge clk) begin
    if (rxb_pop) widx <= widx + 32'h1;
    if (mem_ack && !mem_we) rd_cnt[mem_addr[11:2]]++;
    if (vec_valid) vq.push_back(vec);
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("MISMATCH wait expected done seen timeout");
    print_verdict();
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      bus_rd(ADDR_STAT, rd_val);
      if (rd_val[1:0] === 2'b00) return;
    end
    hang();
  endtask
  task automatic rx_xfer(input logic [7:0] ch, input logic [15:0] len, input rxd_err_s err);
    @(posedge clk);
    rxb_req <= 1'b1;
    rxb_ch <= ch;
    rxb_len <= len;
    rxb_eop <= 1'b1;
    rxb_err <= err;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      #1;
      if (rxb_ack === 1'b1) begin
        @(posedge clk);
        rxb_req <= 1'b0;
        wait_idle();
        return;
      end
    end
    hang();
  endtask
  task automatic vec_chk(input logic [15:0] e);
    check("vector", {16'h0, e}, vq.size() > 0 ? {16'h0, vq.pop_front()} : 32'hFFFF_FFFF);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    bus_rd(ADDR_STAT, rd_val);
    check("stat reset", 32'h0, rd_val);
    bus_wr(4'hC, 32'hFFFF_FFFF);
    bus_rd(4'hC, rd_val);
    check("unmapped", 32'h0, rd_val);
    bus_wr(ADDR_FRDA, 32'h0000_0103);
    bus_rd(ADDR_FRDA, rd_val);
    check("list address", 32'h0000_0100, rd_val);
  endtask
  task automatic sc_chain();
    bus_wr(ADDR_CMD, 32'h0000_0103);
    wait_idle();
    check("fetch w0", 32'h1, rd_cnt[64]);
    check("fetch w2", 32'h1, rd_cnt[66]);
    bus_rd(ADDR_STAT, rd_val);
    check("stat loaded", 32'h7, {29'h0, rd_val[4:2]});
    w0 = widx;
    rx_xfer(8'h07, 16'h0004, '0);
    check("idle channel", w0, widx);
    check("idle vectors", 32'h0, vq.size());
    lat <= 4'h2;
    rx_xfer(8'h03, 16'h000C, 5'b00100);
    check("data 0", 32'hD000_0000 + w0, mem_u.mem[256]);
    check("data 1", 32'hD000_0001 + w0, mem_u.mem[257]);
    check("data 2", 32'hD000_0002 + w0, mem_u.mem[320]);
    check("status full", 32'h4000_0008, mem_u.mem[67]);
    check("status end", 32'hC004_0004, mem_u.mem[131]);
    vec_chk({VEC_PKT_END, 6'h06, 8'h03});
    vec_chk({VEC_HOST, 6'h06, 8'h03});
  endtask
  task automatic sc_hold();
    rx_xfer(8'h03, 16'h0004, '0);
    check("repoll w0", 32'h2, rd_cnt[128]);
    check("repoll w1", 32'h2, rd_cnt[129]);
    check("repoll w2", 32'h1, rd_cnt[130]);
    bus_rd(ADDR_STAT, rd_val);
    check("stat off", 32'h0, {31'h0, rd_val[2]});
    check("held vectors", 32'h0, vq.size());
  endtask
  task automatic sc_resume();
    mem_u.mem[128] = 32'h2006_0010;
    lat <= 4'h0;
    bus_wr(ADDR_CMD, 32'h0000_0203);
    wait_idle();
    check("resume poll", 32'h3, rd_cnt[128]);
    check("next fetch", 32'h1, rd_cnt[192]);
    bus_rd(ADDR_STAT, rd_val);
    check("stat on", 32'h1, {31'h0, rd_val[2]});
    w0 = widx;
    rx_xfer(8'h03, 16'h0004, '0);
    check("offset gap", 32'h0, mem_u.mem[384]);
    check("offset data", 32'hD000_0000 + w0, mem_u.mem[385]);
    check("status d2", 32'hC000_0004, mem_u.mem[195]);
    vec_chk({VEC_PKT_END, 6'h07, 8'h03});
  endtask
  task automatic sc_abort();
    bus_wr(ADDR_FRDA, 32'h0000_0100);
    bus_wr(ADDR_CMD, 32'h0000_0303);
    wait_idle();
    check("abort status", 32'h4001_0004, mem_u.mem[195]);
    check("relink fetch", 32'h2, rd_cnt[64]);
    bus_rd(ADDR_STAT, rd_val);
    check("stat relinked", 32'h7, {29'h0, rd_val[4:2]});
    check("abort vectors", 32'h0, vq.size());
  endtask
  // main sequence
  initial begin
    {rst, wr, rd, rxb_req, rxb_eop} = 5'b10000;
    {addr, lat, wdata, rxb_ch, rxb_len, rxb_err, widx} = '0;
    for (int i = 0; i < 1024; i++) mem_u.mem[i] = 32'h0;
    mem_u.mem[64] = 32'h0005_0008;
    mem_u.mem[65] = 32'h0000_0200;
    mem_u.mem[66] = 32'h0000_0400;
    mem_u.mem[128] = 32'h6006_0010;
    mem_u.mem[129] = 32'h0000_0300;
    mem_u.mem[130] = 32'h0000_0500;
    mem_u.mem[192] = 32'h4407_0010;
    mem_u.mem[194] = 32'h0000_0600;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sc_regs();
    sc_chain();
    sc_hold();
    sc_resume();
    sc_abort();
    print_verdict();
  end
endmodule
